// file: logic/pas_setup.v
// proximity adc setup registers with apb slave and conversion sequencer
`timescale 1ns/10ps
`include "pas_consts.vh"
module pas_setup #(
    parameter INTEG_CLKS = `PAS_INTEG_BASE,
    parameter ADC_DIV    = `PAS_ADC_DIV
) (
    input  wire        ref_clk,
    input  wire        resetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire        conv_start,
    output wire        conv_busy,
    output reg         led_drive_r,
    output reg         adc_integrate_r,
    output reg         conv_done_r,
    output reg         adc_high_range_r,
    output reg  [7:0]  adc_input_sel_r,
    output reg  [2:0]  prox_gain_exp_r,
    output reg         prox_measure_mode_r
);
    // ==========================================================
    // register file
    reg  [7:0] rec_r;
    reg  [7:0] gain_r;
    reg  [7:0] misc_r;
    reg  [7:0] amb_r;

    wire       acc      = psel & penable;
    wire       aligned  = (paddr[1:0] == 2'b00);
    wire [7:0] idx      = {2'b00, paddr[7:2]};
    wire       hi_zero  = (paddr[11:8] == 4'h0);
    wire       hit_rec  = aligned & hi_zero & (idx == `PAS_IDX_RECOVERY);
    wire       hit_gain = aligned & hi_zero & (idx == `PAS_IDX_GAIN);
    wire       hit_misc = aligned & hi_zero & (idx == `PAS_IDX_MISC);
    wire       hit_amb  = aligned & hi_zero & (idx == `PAS_IDX_AMB_IR);
    wire       hit_any  = hit_rec | hit_gain | hit_misc | hit_amb;
    wire       wr       = acc & pwrite & hit_any & pstrb[0];

    // zero-wait slave: each access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = acc & ~hit_any;

    always @(posedge ref_clk) begin
        if (!resetn) begin
            rec_r  <= `PAS_RST_RECOVERY;
            gain_r <= `PAS_RST_GAIN;
            misc_r <= `PAS_RST_MISC;
            amb_r  <= `PAS_RST_AMB_IR;
        end else if (wr) begin
            // reserved bits masked off on write
            if (hit_rec) begin
                rec_r <= pwdata[7:0] & `PAS_MASK_RECOVERY;
            end
            if (hit_gain) begin
                gain_r <= pwdata[7:0] & `PAS_MASK_GAIN;
            end
            if (hit_misc) begin
                misc_r <= pwdata[7:0] & `PAS_MASK_MISC;
            end
            if (hit_amb) begin
                amb_r <= pwdata[7:0];
            end
        end
    end

    // read data registered during setup so it is stable in access phase
    always @(posedge ref_clk) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= 32'h0000_0000;
            if (hit_rec) begin
                prdata <= {24'h00_0000, rec_r};
            end
            if (hit_gain) begin
                prdata <= {24'h00_0000, gain_r};
            end
            if (hit_misc) begin
                prdata <= {24'h00_0000, misc_r};
            end
            if (hit_amb) begin
                prdata <= {24'h00_0000, amb_r};
            end
        end
    end

    // ==========================================================
    // recovery clock count lookup
    wire [2:0] rec_sel = rec_r[`PAS_REC_LSB+2:`PAS_REC_LSB];
    reg  [9:0] rec_clks;
    always @* begin
        case (rec_sel)
            3'd0:    rec_clks = 10'd1;
            3'd1:    rec_clks = 10'd7;
            3'd2:    rec_clks = 10'd15;
            3'd3:    rec_clks = 10'd31;
            3'd4:    rec_clks = 10'd63;
            3'd5:    rec_clks = 10'd127;
            3'd6:    rec_clks = 10'd255;
            default: rec_clks = 10'd511;
        endcase
    end

    // ==========================================================
    // conversion sequencer
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_REC  = 4'b0010;
    localparam [3:0] S_INT  = 4'b0100;
    localparam [3:0] S_END  = 4'b1000;

    reg  [3:0]  state_r;
    reg  [3:0]  state_nxt;
    reg         load;
    reg  [23:0] load_val;
    wire        t_done;
    wire        t_busy;
    wire [2:0]  g = gain_r[2:0];
    wire        normal_mode = misc_r[`PAS_MODE_BIT];

    // settings are latched at start so mid-conversion writes cannot
    // change the timing of a conversion already in flight
    wire [31:0] rec_prod   = {22'h00_0000, rec_clks} * ADC_DIV;
    wire [31:0] integ_prod = INTEG_CLKS * ADC_DIV;
    wire [23:0] rec_cnt    = rec_prod[23:0] << g;
    wire [23:0] integ_cnt  = integ_prod[23:0] << prox_gain_exp_r;

    always @* begin
        state_nxt = state_r;
        load      = 1'b0;
        load_val  = 24'h00_0000;
        case (state_r)
            S_IDLE: begin
                if (conv_start) begin
                    state_nxt = S_REC;
                    load      = 1'b1;
                    load_val  = rec_cnt;
                end
            end
            S_REC: begin
                if (t_done) begin
                    state_nxt = S_INT;
                    load      = 1'b1;
                    load_val  = integ_cnt;
                end
            end
            S_INT: begin
                if (t_done) begin
                    state_nxt = S_END;
                end
            end
            S_END: begin
                state_nxt = S_IDLE;
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            state_r             <= S_IDLE;
            led_drive_r         <= 1'b0;
            adc_integrate_r     <= 1'b0;
            conv_done_r         <= 1'b0;
            adc_high_range_r    <= 1'b0;
            adc_input_sel_r     <= `PAS_SEL_SMALL_IR;
            prox_gain_exp_r     <= 3'd0;
            prox_measure_mode_r <= 1'b1;
        end else begin
            state_r     <= state_nxt;
            conv_done_r <= (state_r == S_END);
            if (state_r == S_IDLE && conv_start) begin
                adc_high_range_r    <= misc_r[`PAS_RANGE_BIT];
                prox_measure_mode_r <= normal_mode;
                prox_gain_exp_r     <= g;
                adc_input_sel_r     <= amb_r;
            end
            adc_integrate_r <= (state_nxt == S_INT);
            // led only fires in normal proximity mode
            led_drive_r <= (state_nxt == S_INT) &
                           ((state_r == S_IDLE) ? normal_mode
                                                : prox_measure_mode_r);
        end
    end

    assign conv_busy = (state_r != S_IDLE);

    pas_gain_timer #(
        .W(24)
    ) u_timer (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .load     (load),
        .count_in (load_val),
        .busy     (t_busy),
        .done_r   (t_done)
    );
endmodule

// file: logic/pas_consts.vh
// register map, field layout and timing constants of the proximity adc setup
// Functional notes
// - the recovery select picks 1, 7, 15, 31, 63, 127, 255 or 511 adc clocks before each proximity conversion.
// - the recovery lasts that clock count times 50 ns times two to the gain exponent.
// - led pulse width and integration time are both stretched by two to the gain exponent.
// - the range bit selects normal sensitivity when clear and high signal range when set.
// - the mode bit selects raw adc measurement when clear and normal proximity when set.
// - the misc setting resets to 0x04, normal proximity mode with normal range.
// - ambient ir selector code 0x00 picks the small ir diode and 0x03 the large.
// - in raw mode the ir led drives stay off during proximity conversions.
`ifndef PAS_CONSTS_VH
`define PAS_CONSTS_VH

// ==========================================================
// register indices (byte address is index times four)
`define PAS_IDX_RECOVERY     8'h0A
`define PAS_IDX_GAIN         8'h0B
`define PAS_IDX_MISC         8'h0C
`define PAS_IDX_AMB_IR       8'h0E

// ==========================================================
// reset values
`define PAS_RST_RECOVERY     8'h70
`define PAS_RST_GAIN         8'h00
`define PAS_RST_MISC         8'h04
`define PAS_RST_AMB_IR       8'h00

// ==========================================================
// writable bit masks
`define PAS_MASK_RECOVERY    8'h70
`define PAS_MASK_GAIN        8'h07
`define PAS_MASK_MISC        8'h24
`define PAS_MASK_AMB_IR      8'hFF

// ==========================================================
// field positions
`define PAS_REC_LSB          4
`define PAS_RANGE_BIT        5
`define PAS_MODE_BIT         2

// ==========================================================
// input selector codes
`define PAS_SEL_SMALL_IR     8'h00
`define PAS_SEL_LARGE_IR     8'h03

// ==========================================================
// timing
`define PAS_ADC_BASE_NS      50
`define PAS_SYS_CLK_NS       10
`define PAS_ADC_DIV          ((`PAS_ADC_BASE_NS + `PAS_SYS_CLK_NS - 1) / `PAS_SYS_CLK_NS)
`define PAS_INTEG_BASE       16

`endif

// file: logic/pas_gain_timer.v
// down counter measuring adc-clock periods scaled by the gain exponent
`timescale 1ns/10ps
module pas_gain_timer #(
    parameter W = 24
) (
    input  wire         ref_clk,
    input  wire         resetn,
    input  wire         load,
    input  wire [W-1:0] count_in,
    output wire         busy,
    output reg          done_r
);
    reg [W-1:0] cnt_r;

    assign busy = (cnt_r != {W{1'b0}});

    always @(posedge ref_clk) begin
        if (!resetn) begin
            cnt_r  <= {W{1'b0}};
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            // done leads the last count by one edge so that the phase
            // it ends lasts exactly the loaded number of cycles
            if (load) begin
                cnt_r  <= count_in;
                done_r <= (count_in == {{(W-1){1'b0}}, 1'b1});
            end else if (busy) begin
                cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
                if (cnt_r == {{(W-2){1'b0}}, 2'b10}) begin
                    done_r <= 1'b1;
                end
            end
        end
    end
endmodule

// file: tb/pas_setup_assertions.sv
// port assertions for the proximity adc setup block
`timescale 1ns/10ps
module pas_setup_assertions #(
    parameter INTEG_CLKS = 16,
    parameter ADC_DIV    = 5
) (
    input wire        ref_clk,
    input wire        resetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] prdata,
    input wire        conv_busy,
    input wire        led_drive_r,
    input wire        adc_integrate_r,
    input wire        conv_done_r,
    input wire        adc_high_range_r,
    input wire [2:0]  prox_gain_exp_r,
    input wire        prox_measure_mode_r
);
// ====
// integration length
reg [23:0] icnt_r;
always @(posedge ref_clk) begin
    icnt_r <= (resetn && adc_integrate_r) ? icnt_r + 24'h0001 : 24'h0000;
end
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!resetn);
chk_led_raw_off: assert property (!prox_measure_mode_r |-> !led_drive_r)
    else $error("led driven in raw mode");
chk_led_normal: assert property
    (adc_integrate_r && prox_measure_mode_r |-> led_drive_r)
    else $error("led idle in normal mode");
chk_led_in_integ: assert property (led_drive_r |-> adc_integrate_r)
    else $error("led outside integration");
chk_integ_len: assert property ($fell(adc_integrate_r) |->
    icnt_r == ((INTEG_CLKS * ADC_DIV) << prox_gain_exp_r))
    else $error("integration length wrong");
chk_done_after: assert property ($fell(adc_integrate_r) |=> conv_done_r)
    else $error("done late");
chk_done_pulse: assert property (conv_done_r |=> !conv_done_r)
    else $error("done too long");
chk_hold_copy: assert property (conv_busy |=> $stable(prox_gain_exp_r) &&
    $stable(prox_measure_mode_r) && $stable(adc_high_range_r))
    else $error("settings moved mid conversion");
chk_reset_vals: assert property (disable iff (1'b0) !resetn |=>
    prox_measure_mode_r && !adc_high_range_r && prox_gain_exp_r == 3'h0)
    else $error("reset values wrong");
chk_rsvd_zero: assert property (psel && penable && !pwrite |->
    prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
endmodule

bind pas_setup pas_setup_assertions #(
    .INTEG_CLKS(INTEG_CLKS), .ADC_DIV(ADC_DIV)) pas_setup_assertions_i (.*);

// file: tb/pas_host_model.sv
// host controller model issuing apb transfers
`timescale 1ns/10ps
module pas_host_model (
    input  wire        ref_clk,
    input  wire        pready,
    input  wire [31:0] prdata,
    input  wire        pslverr,
    output reg         psel = 1'b0,
    output reg         penable = 1'b0,
    output reg         pwrite = 1'b0,
    output reg  [11:0] paddr = 12'h000,
    output reg  [31:0] pwdata = 32'h0000_0000,
    output reg  [3:0]  pstrb = 4'hf,
    output reg         hang = 1'b0
);
// leading edge keeps back-to-back calls off a shared time step
task xfer(input [11:0] a, input w, input [31:0] wd,
          output [31:0] rd, output er);
    integer n;
    begin
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        @(posedge ref_clk);
        while (!pready && n < 50) begin
            n = n + 1;
            @(posedge ref_clk);
        end
        rd = prdata;
        er = pslverr;
        if (n >= 50)
            hang <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
    end
endtask
endmodule

// file: tb/tb_prox_adc_setup_params.sv
// self-checking bench for the proximity adc setup block
`timescale 1ns/10ps
module tb_prox_adc_setup_params;
reg         ref_clk = 1'b0;
reg         resetn = 1'b0;
reg         conv_start = 1'b0;
wire        psel, penable, pwrite, pready, pslverr, hang, conv_busy;
wire        led_drive_r, adc_integrate_r, conv_done_r;
wire        adc_high_range_r, prox_measure_mode_r;
wire [2:0]  prox_gain_exp_r;
wire [7:0]  adc_input_sel_r;
wire [11:0] paddr;
wire [31:0] pwdata, prdata;
wire [3:0]  pstrb;
reg  [31:0] q, d, x;
reg         e, led, mode, rng;
integer     mismatches = 0, comparisons = 0, i, k, n, g;
localparam [47:0] ADDRS = {12'h038, 12'h030, 12'h02C, 12'h028};
localparam [31:0] RSTS = 32'h0004_0070;
localparam [31:0] MASKS = 32'hFF24_0770;
always #5 ref_clk = ~ref_clk;
pas_setup #(.INTEG_CLKS(1)) pas_setup_i (.ref_clk(ref_clk),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .conv_start(conv_start),
    .conv_busy(conv_busy), .led_drive_r(led_drive_r),
    .adc_integrate_r(adc_integrate_r), .conv_done_r(conv_done_r),
    .adc_high_range_r(adc_high_range_r), .adc_input_sel_r(adc_input_sel_r),
    .prox_gain_exp_r(prox_gain_exp_r),
    .prox_measure_mode_r(prox_measure_mode_r));
pas_host_model pas_host_model_i (.ref_clk(ref_clk), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .hang(hang));
// ====
// checking
task chk(input [8*8:1] nm, input [31:0] ex, input [31:0] got);
    begin
        comparisons = comparisons + 1;
        if (got !== ex) begin
            mismatches = mismatches + 1;
            $display("MISMATCH %0s exp %h got %h", nm, ex, got);
        end
    end
endtask
task close_out;
    begin
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
endtask
task wait_on(input integer lim);
    begin
        if (n >= lim) begin
            mismatches = mismatches + 1;
            close_out;
        end
    end
endtask
always @(posedge hang) begin
    mismatches = mismatches + 1;
    close_out;
end
// ====
// sequence
initial begin
    x = $urandom(20);
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
        pas_host_model_i.xfer(ADDRS[i*12 +: 12], 1'b0, 32'h0, q, e);
        chk("reset", RSTS[i*8 +: 8], q);
    end
    pas_host_model_i.xfer(12'h034, 1'b0, 32'h0, q, e);
    chk("slverr", 32'h1, e);
    $display("test reset and map done");
    for (k = 0; k < 8; k = k + 1) begin
        for (i = 0; i < 4; i = i + 1) begin
            d = (k == 0) ? 32'hFFFF_FFFF : $urandom;
            pas_host_model_i.xfer(ADDRS[i*12 +: 12], 1'b1, d, q, e);
            pas_host_model_i.xfer(ADDRS[i*12 +: 12], 1'b0, 32'h0, q, e);
            chk("readback", d & MASKS[i*8 +: 8], q);
        end
    end
    $display("test register access done");
    for (i = 0; i < 8; i = i + 1) begin
        g = (7 - i > 5) ? 0 : 7 - i;
        mode = $urandom % 2;
        rng = $urandom % 2;
        pas_host_model_i.xfer(12'h028, 1'b1, i << 4, q, e);
        pas_host_model_i.xfer(12'h02C, 1'b1, g, q, e);
        pas_host_model_i.xfer(12'h030, 1'b1, (rng << 5) | (mode << 2), q, e);
        pas_host_model_i.xfer(12'h038, 1'b1, i[0] ? 3 : 0, q, e);
        @(posedge ref_clk);
        conv_start <= 1'b1;
        @(posedge ref_clk);
        conv_start <= 1'b0;
        n = 0;
        while (!adc_integrate_r && n < 9000) begin
            @(posedge ref_clk);
            #1;
            n = n + 1;
        end
        wait_on(9000);
        d = ((i == 0) ? 1 : (1 << (i + 2)) - 1) * 5 << g;
        chk("recovery", d, n);
        chk("gain", g, prox_gain_exp_r);
        chk("busy", 32'h1, conv_busy);
        chk("mode", mode, prox_measure_mode_r);
        chk("range", rng, adc_high_range_r);
        chk("insel", i[0] ? 3 : 0, adc_input_sel_r);
        led = led_drive_r;
        n = 0;
        while (!conv_done_r && n < 500) begin
            @(posedge ref_clk);
            #1;
            led = led | led_drive_r;
            n = n + 1;
        end
        wait_on(500);
        chk("led", mode, led);
    end
    $display("test conversions done");
    close_out;
end
endmodule
